/* rtl/eeprom_ctrl.sv */
// Purpose: data eeprom row-latch write controller with avalon-mm registers
// Assumes: option bits and power requests are synchronous to clk
// Notes: array is flip-flops; a read is answered one cycle after request
module eeprom_ctrl
    import eeprom_ctrl_pkg::*;
#(
    parameter int DEPTH = 256,
    parameter int PROG_CYCLES = eeprom_ctrl_pkg::PROG_CYCLES_DEF
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [11:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic data_driven,
    // power modes
    input wire logic wait_req,
    input wire logic active_halt_req,
    input wire logic halt_req,
    output logic ee_in_wait,
    output logic ee_in_halt,
    // options and flash side
    input wire logic readout_protect_option,
    input wire logic write_protect_option,
    input wire logic ext_access,
    output eeprom_ctrl_pkg::flash_ctrl_t flash_program_control,
    output logic erase_all
);
    import eeprom_ctrl_pkg::*;

    localparam int AW = $clog2(DEPTH);

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    logic ack_r;
    logic [7:0] readdata_r;
    logic drv_r;
    logic wr_go;
    logic rd_go;
    logic sel_ee;
    logic sel_csr;
    logic sel_flash_program_control;
    logic [AW-1:0] idx;
    logic [ROW_BITS-1:0] col;
    logic [7:0] wd;

    assign sel_ee = address[11:10] == EE_WIN_TAG;
    assign sel_csr = address == CTRL_STATUS_OFS;
    assign sel_flash_program_control = address == FLASH_CTRL_OFS;
    assign idx = address[AW+1:2];
    assign col = address[ROW_BITS+1:2];
    assign wd = writedata[7:0];
    assign waitrequest = (read | write) & ~ack_r;
    assign wr_go = write & ack_r;
    assign rd_go = read & ~ack_r;
    assign readdata = {24'h000000, readdata_r};
    assign data_driven = drv_r;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ack_r <= 1'b0;
        else
            ack_r <= (read | write) & ~ack_r;
    end

    ////////////////////////////////////////////////////////////////////////
    // state, latches and array
    ee_state_t mode_r;
    logic [15:0] tmr_r;
    logic [7:0] mem_r [DEPTH];
    logic [7:0] lat_r [ROW_BYTES];
    logic [ROW_BYTES-1:0] vld_r;
    logic [AW-ROW_BITS-1:0] row_r;
    logic rop_prev_r;
    logic prog_done;
    logic rop_block;
    logic csr_wr;

    // extraction only matters for accesses from outside the running code
    assign rop_block = readout_protect_option & ext_access;
    assign prog_done = mode_r == MODE_PROG && tmr_r == 16'(PROG_CYCLES - 1) && !halt_req;
    assign csr_wr = wr_go & sel_csr;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            mode_r <= MODE_READ;
        end
        else if (halt_req && mode_r == MODE_PROG)
        begin
            mode_r <= MODE_WRITE;
        end
        else if (prog_done)
        begin
            mode_r <= MODE_READ;
        end
        else if (csr_wr)
        begin
            unique case (mode_r)
                MODE_READ:
                begin
                    if (wd[LATCH_ACCESS_POS])
                        mode_r <= MODE_WRITE;
                end
                MODE_WRITE:
                begin
                    if (wd[PROGRAM_START_POS])
                        mode_r <= MODE_PROG;
                    else if (!wd[LATCH_ACCESS_POS])
                        mode_r <= MODE_READ;
                end
                MODE_PROG:
                begin
                    // latch-access stays set while program-start is set
                    if (!wd[PROGRAM_START_POS])
                        mode_r <= MODE_WRITE;
                end
                default:
                    mode_r <= MODE_READ;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            tmr_r <= 16'h0000;
        else if (mode_r == MODE_PROG && !halt_req)
            tmr_r <= tmr_r + 16'h0001;
        else
            tmr_r <= 16'h0000;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            vld_r <= '0;
            row_r <= '0;
        end
        else if (prog_done || (mode_r == MODE_WRITE && csr_wr && !wd[LATCH_ACCESS_POS])
                 || erase_all)
        begin
            vld_r <= '0;
        end
        else if (wr_go && sel_ee && mode_r == MODE_WRITE && !rop_block)
        begin
            vld_r[col] <= 1'b1;
            row_r <= idx[AW-1:ROW_BITS];
        end
    end

    // a second write to one latch keeps only bits high in both values
    always_ff @(posedge clk)
    begin
        if (wr_go && sel_ee && mode_r == MODE_WRITE && !rop_block)
            lat_r[col] <= vld_r[col] ? (lat_r[col] & wd) : wd;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rop_prev_r <= 1'b0;
        else
            rop_prev_r <= readout_protect_option;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            erase_all <= 1'b0;
        else
            erase_all <= rop_prev_r & ~readout_protect_option;
    end

    // no reset on the array: it models non-volatile cells
    always_ff @(posedge clk)
    begin
        for (int i = 0; i < DEPTH; i++)
        begin
            if (erase_all)
                mem_r[i] <= ERASED;
            else if (prog_done && i[AW-1:ROW_BITS] == row_r && vld_r[i % ROW_BYTES])
                mem_r[i] <= lat_r[i % ROW_BYTES];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data; latches have no read path
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            readdata_r <= RST8;
            drv_r <= 1'b0;
        end
        else if (rd_go)
        begin
            drv_r <= !(sel_ee && (mode_r != MODE_READ || rop_block));
            if (sel_ee)
                readdata_r <= (mode_r == MODE_READ && !rop_block) ? mem_r[idx] : RST8;
            else if (sel_csr)
                readdata_r <= {6'h00, mode_r != MODE_READ, mode_r == MODE_PROG};
            else if (sel_flash_program_control)
                readdata_r <= {5'h00, flash_program_control};
            else
                readdata_r <= RST8;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // power modes
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ee_in_wait <= 1'b0;
            ee_in_halt <= 1'b0;
        end
        else
        begin
            ee_in_wait <= (wait_req | active_halt_req) & (mode_r != MODE_PROG | ee_in_wait);
            ee_in_halt <= halt_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // flash control with key unlock
    key_state_t key_r;
    logic fc_wr;

    assign fc_wr = wr_go & sel_flash_program_control;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            key_r <= FK_LOCKED;
        else if (fc_wr)
        begin
            unique case (key_r)
                FK_LOCKED:
                    key_r <= (wd == KEY1) ? FK_KEY1 : FK_LOCKED;
                FK_KEY1:
                    key_r <= (wd == KEY2) ? FK_OPEN : FK_LOCKED;
                FK_OPEN:
                    key_r <= FK_OPEN;
                default:
                    key_r <= FK_LOCKED;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            flash_program_control <= '0;
        else if (fc_wr && key_r == FK_OPEN && !readout_protect_option && !write_protect_option)
            flash_program_control <= wd[OPTION_SELECT_POS:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    // separate age count, so the length checks do not lean on the timer that they judge
    logic [15:0] prog_age_r;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            prog_age_r <= 16'h0000;
        else if (mode_r == MODE_PROG)
            prog_age_r <= prog_age_r + 16'h0001;
        else
            prog_age_r <= 16'h0000;
    end

    a_rd_undriven: assert property (@(posedge clk) disable iff (rst)
        rd_go && sel_ee && mode_r != MODE_READ |=> !data_driven && readdata_r == 8'h00)
        else $error("eeprom read in write mode drove the bus");
    a_wr_discard: assert property (@(posedge clk) disable iff (rst)
        wr_go && sel_ee && mode_r == MODE_READ && !erase_all |=> $stable(vld_r))
        else $error("write in read mode reached a latch");
    a_latch_store: assert property (@(posedge clk) disable iff (rst)
        wr_go && sel_ee && mode_r == MODE_WRITE && !rop_block && !erase_all |=> vld_r[$past(col)])
        else $error("write mode byte not latched");
    a_prog_ends: assert property (@(posedge clk) disable iff (rst)
        mode_r == MODE_PROG |-> prog_age_r < 16'(PROG_CYCLES))
        else $error("programming cycle overran its length");
    a_prog_length: assert property (@(posedge clk) disable iff (rst)
        prog_done |-> prog_age_r == 16'(PROG_CYCLES - 1))
        else $error("programming cycle ended early");
    a_cycle_clear: assert property (@(posedge clk) disable iff (rst)
        prog_done |=> mode_r == MODE_READ && vld_r == '0)
        else $error("latches or latch-access survive cycle end");
    a_halt_abort: assert property (@(posedge clk) disable iff (rst)
        halt_req && mode_r == MODE_PROG |=> mode_r != MODE_PROG ##0 ee_in_halt)
        else $error("halt did not abort programming");
    a_wait_defer: assert property (@(posedge clk) disable iff (rst)
        wait_req && mode_r == MODE_PROG && !ee_in_wait |=> !ee_in_wait)
        else $error("wait entered during programming");
    a_rsvd_zero: assert property (@(posedge clk) disable iff (rst)
        read && ack_r && sel_csr |-> readdata[7:2] == 6'h00)
        else $error("reserved status bits not zero");
    a_flash_lock: assert property (@(posedge clk) disable iff (rst)
        fc_wr && key_r != FK_OPEN |=> $stable(flash_program_control))
        else $error("flash control changed while locked");
    a_wp_hold: assert property (@(posedge clk) disable iff (rst)
        write_protect_option |=> $stable(flash_program_control))
        else $error("flash control changed under write protection");

    c_prog_cycle: cover property (@(posedge clk) disable iff (rst) prog_done);
    c_wait_after: cover property (@(posedge clk) disable iff (rst)
        $fell(mode_r == MODE_PROG) && wait_req ##1 ee_in_wait);
    c_unlock: cover property (@(posedge clk) disable iff (rst) key_r == FK_OPEN && fc_wr);
    c_erase: cover property (@(posedge clk) disable iff (rst) erase_all);

endmodule : eeprom_ctrl

/* rtl/eeprom_ctrl_pkg.sv */
// Purpose: constants and types for the data eeprom write controller
// Assumes: 8-bit registers, one per aligned 32-bit word of an avalon-mm slave
// Notes: eeprom bytes sit one per word in a window starting at 0x400
package eeprom_ctrl_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register map (byte addresses)
    localparam logic [11:0] CTRL_STATUS_OFS = 12'h020;
    localparam logic [11:0] FLASH_CTRL_OFS = 12'h024;
    localparam logic [1:0] EE_WIN_TAG = 2'h1;

    ////////////////////////////////////////////////////////////////////////
    // fields and values
    localparam int LATCH_ACCESS_POS = 1;
    localparam int PROGRAM_START_POS = 0;
    localparam int OPTION_SELECT_POS = 2;
    localparam logic [7:0] KEY1 = 8'h56;
    localparam logic [7:0] KEY2 = 8'hAE;
    localparam logic [7:0] RST8 = 8'h00;
    localparam logic [7:0] ERASED = 8'hFF;
    localparam int ROW_BITS = 5;
    localparam int ROW_BYTES = 32;
    localparam int PROG_CYCLES_DEF = 4000;

    ////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0]
    {
        MODE_READ = 2'b00,
        MODE_WRITE = 2'b01,
        MODE_PROG = 2'b10
    } ee_state_t;

    typedef enum logic [1:0]
    {
        FK_LOCKED = 2'b00,
        FK_KEY1 = 2'b01,
        FK_OPEN = 2'b10
    } key_state_t;

    typedef struct packed
    {
        logic option_select_bit;
        logic flash_latch_bit;
        logic flash_program_bit;
    } flash_ctrl_t;

endpackage : eeprom_ctrl_pkg

/* tb/cpu_bus_model.sv */
// Purpose: cpu data bus master model for the eeprom controller
// Assumes: avalon-mm, one request at a time
// Notes: to rises when a transfer gets no answer within 50 edges
module cpu_bus_model
(
    // clock
    input wire logic clk,
    // avalon-mm master
    output logic [11:0] address,
    output logic read,
    output logic write,
    output logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // status
    output logic to
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        address = 12'h000;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h00000000;
        to = 1'b0;
    end

    // request held until waitrequest is seen low at a rising edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [7:0] q);
        bit done;
        done = 1'b0;
        address <= a;
        read <= ~w;
        write <= w;
        writedata <= {24'h000000, d};
        for (int i = 0; i < 50 && !done; i++)
        begin
            @(posedge clk);
            done = (waitrequest === 1'b0);
        end
        q = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
        if (!done)
            to <= 1'b1;
        // one idle edge so the next request never lands in the release step
        @(posedge clk);
    endtask : xfer
endmodule : cpu_bus_model

/* tb/data_eeprom_write_controller_tb_top.sv */
// Purpose: self-checking bench for the eeprom write controller
// Assumes: PROG_CYCLES shortened to 8
// Notes: eeprom byte n sits at 0x400 + 4n
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
    $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module data_eeprom_write_controller_tb_top;
    import eeprom_ctrl_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk = 1'b0, rst = 1'b1, cpu_to;
    logic wait_req = 1'b0, active_halt_req = 1'b0, halt_req = 1'b0;
    logic readout_protect_option = 1'b1, write_protect_option = 1'b0, ext_access = 1'b0;
    logic [11:0] address;
    logic read, write, waitrequest, data_driven, ee_in_wait, ee_in_halt, erase_all;
    logic [31:0] writedata, readdata;
    flash_ctrl_t flash_program_control;
    int n_fail = 0, comparisons = 0;

    always #12.5 clk = ~clk;

    cpu_bus_model cpu (.clk(clk), .address(address), .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .to(cpu_to));
    eeprom_ctrl #(.PROG_CYCLES(8)) uut (.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .data_driven(data_driven),
        .wait_req(wait_req), .active_halt_req(active_halt_req), .halt_req(halt_req), .ee_in_wait(ee_in_wait),
        .ee_in_halt(ee_in_halt), .readout_protect_option(readout_protect_option),
        .write_protect_option(write_protect_option), .ext_access(ext_access),
        .flash_program_control(flash_program_control), .erase_all(erase_all));

    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish

    task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [7:0] q);
        cpu.xfer(w, a, d, q);
        if (cpu_to === 1'b1)
        begin
            n_fail++;
            tally_and_finish();
        end
    endtask : acc

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [7:0] q;
        acc(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [7:0] q);
        acc(1'b0, a, 8'h00, q);
    endtask : rd

    function automatic logic [11:0] ea(input int n);
        return 12'h400 + 12'(4 * n);
    endfunction : ea

    task automatic chk_rd(input string nm, input logic [11:0] a, input logic [7:0] e);
        logic [7:0] q;
        rd(a, q);
        `CHK(nm, e, q)
    endtask : chk_rd

    // a bounded status poll stands in for software counting the cycle
    task automatic poll_idle;
        logic [7:0] q;
        q = 8'hFF;
        for (int i = 0; i < 40 && q !== 8'h00; i++)
            rd(CTRL_STATUS_OFS, q);
        `CHK("status idle", 8'h00, q)
    endtask : poll_idle

    task automatic prog_row(input int n, input logic [7:0] d);
        wr(CTRL_STATUS_OFS, 8'h02);
        wr(ea(n), d);
        wr(CTRL_STATUS_OFS, 8'h03);
    endtask : prog_row

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset_erase;
        chk_rd("status reset", CTRL_STATUS_OFS, 8'h00);
        chk_rd("flash ctrl reset", FLASH_CTRL_OFS, 8'h00);
        readout_protect_option <= 1'b0;
        for (int i = 0; i < 10 && erase_all !== 1'b1; i++)
            @(posedge clk);
        `CHK("erase pulse", 1'b1, erase_all)
        @(posedge clk);
        chk_rd("erased byte", ea(0), ERASED);
        wr(ea(3), 8'h00);
        chk_rd("read mode write", ea(3), ERASED);
        `CHK("driven", 1'b1, data_driven)
        $display("test reset_erase done");
    endtask : t_reset_erase

    task automatic t_program;
        logic [7:0] q;
        wr(CTRL_STATUS_OFS, 8'h02);
        chk_rd("write mode", CTRL_STATUS_OFS, 8'h02);
        wr(ea(65), 8'hF0);
        wr(ea(65), 8'h3C);
        wr(ea(95), 8'hA5);
        rd(ea(65), q);
        `CHK("undriven", 1'b0, data_driven)
        `CHK("latch hidden", 8'h00, q)
        wr(CTRL_STATUS_OFS, 8'h03);
        chk_rd("in progress", CTRL_STATUS_OFS, 8'h03);
        poll_idle();
        chk_rd("and of writes", ea(65), 8'h30);
        chk_rd("row top byte", ea(95), 8'hA5);
        chk_rd("unwritten byte", ea(66), ERASED);
        $display("test program done");
    endtask : t_program

    task automatic t_lat_fall;
        wr(CTRL_STATUS_OFS, 8'h02);
        wr(ea(70), 8'h00);
        wr(CTRL_STATUS_OFS, 8'h00);
        prog_row(71, 8'h11);
        poll_idle();
        chk_rd("dropped latch", ea(70), ERASED);
        chk_rd("kept byte", ea(71), 8'h11);
        $display("test lat_fall done");
    endtask : t_lat_fall

    task automatic t_power;
        prog_row(72, 8'h22);
        wait_req <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK("no wait mid cycle", 1'b0, ee_in_wait)
        repeat (12) @(posedge clk);
        `CHK("wait after cycle", 1'b1, ee_in_wait)
        wait_req <= 1'b0;
        repeat (3) @(posedge clk);
        active_halt_req <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK("active halt wait", 1'b1, ee_in_wait)
        active_halt_req <= 1'b0;
        chk_rd("wait programmed", ea(72), 8'h22);
        prog_row(73, 8'h33);
        halt_req <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK("halt", 1'b1, ee_in_halt)
        halt_req <= 1'b0;
        chk_rd("halt abort", CTRL_STATUS_OFS, 8'h02);
        wr(CTRL_STATUS_OFS, 8'h00);
        $display("test power done");
    endtask : t_power

    // reset in mid-cycle: nothing may be committed
    task automatic t_reset_abort;
        prog_row(74, 8'h44);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk_rd("status after reset", CTRL_STATUS_OFS, 8'h00);
        chk_rd("aborted byte", ea(74), ERASED);
        $display("test reset_abort done");
    endtask : t_reset_abort

    task automatic t_flash;
        wr(FLASH_CTRL_OFS, 8'h07);
        `CHK("locked", 3'b000, flash_program_control)
        wr(FLASH_CTRL_OFS, KEY1);
        wr(FLASH_CTRL_OFS, KEY2);
        wr(FLASH_CTRL_OFS, 8'h07);
        `CHK("unlocked", 3'b111, flash_program_control)
        chk_rd("flash ctrl read", FLASH_CTRL_OFS, 8'h07);
        write_protect_option <= 1'b1;
        wr(FLASH_CTRL_OFS, 8'h00);
        `CHK("write protected", 3'b111, flash_program_control)
        $display("test flash done");
    endtask : t_flash

    // outside accesses under readout protection: no data out, no rewrite
    task automatic t_protect;
        logic [7:0] q;
        readout_protect_option <= 1'b1;
        ext_access <= 1'b1;
        rd(ea(71), q);
        `CHK("protected undriven", 1'b0, data_driven)
        `CHK("protected read", 8'h00, q)
        prog_row(75, 8'h00);
        poll_idle();
        ext_access <= 1'b0;
        chk_rd("protected rewrite", ea(75), ERASED);
        chk_rd("internal read", ea(71), 8'h11);
        $display("test protect done");
    endtask : t_protect

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset_erase();
        t_program();
        t_lat_fall();
        t_power();
        t_reset_abort();
        t_flash();
        t_protect();
        tally_and_finish();
    end
endmodule : data_eeprom_write_controller_tb_top
